// file: core/pao_consts.svh
// Constants for the port alternate-function override block
`ifndef PAO_CONSTS_SVH
`define PAO_CONSTS_SVH
`define PAO_CLK_PERIOD_PS  5000
`define PAO_FILT_NS        50
`define PAO_FILT_CYC       ((`PAO_FILT_NS * 1000 + `PAO_CLK_PERIOD_PS - 1) / `PAO_CLK_PERIOD_PS)
`define PAO_IDX_SCL        0
`define PAO_IDX_SDA        1
`define PAO_IDX_RXD        2
`define PAO_IDX_TXD        3
`define PAO_IDX_CAP1       4
`define PAO_IDX_XCK        5
`define PAO_IDX_TMR1CK     6
`define PAO_IDX_TMR0CK     7
`define PAO_IDX_BOOT       10
`define PAO_IDX_IRQ6       14
`define PAO_IDX_TCK        20
`define PAO_IDX_TMS        21
`define PAO_IDX_TDO        22
`define PAO_IDX_TDI        23
`define PAO_JTAG_PU_MASK   8'hB0
`define PAO_RST_PINS       24'h000000
`define PAO_RST_FILT       2'h3
`define PAO_RST_FCNT       4'h0
`define PAO_RST_BOOT       1'b0
`endif

// file: core/pao_pkg.sv
// Types for the port alternate-function override block
package pao_pkg;
  typedef enum logic [1:0] {
    BOOT_WAIT    = 2'b00,
    BOOT_SYNC    = 2'b01,
    BOOT_CAPTURE = 2'b10,
    BOOT_DONE    = 2'b11
  } pao_boot_t;

  typedef struct packed {
    logic [23:0]      s1;
    logic [23:0]      s2;
    logic [1:0][3:0]  fcnt;
    logic [1:0]       fval;
    logic [23:0]      pin;
    logic [23:0]      oe;
    logic [23:0]      out;
    logic [23:0]      pu;
    pao_boot_t        boot_st;
    logic             boot_sel;
  } pao_state_t;
endpackage : pao_pkg

// file: core/pao_top.sv
// Port D/E/F alternate-function override logic between peripherals and pads
`timescale 1ns/1ps
module pao_top
  import pao_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // Port registers
  input  wire logic [7:0]  PORT_DATA_D,
  input  wire logic [7:0]  PORT_DIR_D,
  input  wire logic [7:0]  PORT_DATA_E,
  input  wire logic [7:0]  PORT_DIR_E,
  input  wire logic [7:0]  PORT_DATA_F,
  input  wire logic [7:0]  PORT_DIR_F,
  input  wire logic        GLOBAL_PULLUP_DISABLE,
  input  wire logic        INPUT_DISABLE_SLEEP,
  // Serial unit
  input  wire logic        SERIAL_RX_ENABLE,
  input  wire logic        SERIAL_TX_ENABLE,
  input  wire logic        SERIAL_TX_OUT,
  input  wire logic        SERIAL_SYNC_MODE,
  input  wire logic        SERIAL_SYNC_CLOCK_OUT,
  output logic             SERIAL_RX_IN,
  output logic             SERIAL_SYNC_CLOCK_IN,
  // Two-wire interface
  input  wire logic        TWO_WIRE_ENABLE,
  input  wire logic        TW_SDA_PULL_LOW,
  input  wire logic        TW_SCL_PULL_LOW,
  output logic             TW_SDA_IN,
  output logic             TW_SCL_IN,
  // Timers
  input  wire logic        TIMER0_COMPARE_B_EN,
  input  wire logic        TIMER0_COMPARE_B_OUT,
  output logic             TIMER0_EXT_CLOCK_IN,
  output logic             TIMER1_EXT_CLOCK_IN,
  output logic             TIMER1_CAPTURE_IN,
  // External interrupts
  input  wire logic [3:0]  EXT_IRQ_EN_D,
  input  wire logic        EXT_IRQ6_EN,
  output logic [3:0]       EXT_IRQ_IN_D,
  output logic             EXT_IRQ6_IN,
  // Boot select
  input  wire logic        BOOT_SELECT_FUSE,
  output logic             BOOT_FROM_LOADER,
  // Test access port
  input  wire logic        JTAG_ENABLE,
  input  wire logic        TAP_SHIFT_IR,
  input  wire logic        TAP_SHIFT_DR,
  input  wire logic        TAP_TDO,
  output logic             TAP_TDI,
  output logic             TAP_TMS,
  output logic             TAP_TCK,
  // Digital pin readback
  output logic [7:0]       PIN_D,
  output logic [7:0]       PIN_E,
  output logic [7:0]       PIN_F,
  // Pads
  input  wire logic [7:0]  PAD_D_IN,
  input  wire logic [7:0]  PAD_E_IN,
  input  wire logic [7:0]  PAD_F_IN,
  output logic [7:0]       PAD_D_OUT,
  output logic [7:0]       PAD_D_OE,
  output logic [7:0]       PAD_D_PULLUP,
  output logic [7:0]       PAD_E_OUT,
  output logic [7:0]       PAD_E_OE,
  output logic [7:0]       PAD_E_PULLUP,
  output logic [7:0]       PAD_F_OUT,
  output logic [7:0]       PAD_F_OE,
  output logic [7:0]       PAD_F_PULLUP
);
  `include "pao_consts.svh"

  localparam logic [3:0] FILT_LAST    = 4'(`PAO_FILT_CYC - 1);
  localparam logic [7:0] JTAG_PU_MASK = `PAO_JTAG_PU_MASK;

  pao_state_t st_r;
  pao_state_t st_nxt;

  logic [23:0] data_reg;
  logic [23:0] dir_reg;
  logic [23:0] pu_ov_en, pu_ov_val, dir_ov_en, dir_ov_val, val_ov_en, val_ov_val, ie_ov_en, ie_ov_val;
  logic [23:0] pu_f, dd_f, pv_f, die_f;
  logic        xck_out_en;

  assign data_reg   = {PORT_DATA_F, PORT_DATA_E, PORT_DATA_D};
  assign dir_reg    = {PORT_DIR_F, PORT_DIR_E, PORT_DIR_D};
  assign xck_out_en = SERIAL_SYNC_MODE & PORT_DIR_D[`PAO_IDX_XCK];

  //////////////////////////////////////////////////////////////////////////////
  // Override sources per pin; unlisted pins keep register control
  always_comb begin
    pu_ov_en   = '0;
    pu_ov_val  = '0;
    dir_ov_en  = '0;
    dir_ov_val = '0;
    val_ov_en  = '0;
    val_ov_val = '0;
    ie_ov_en   = '0;
    ie_ov_val  = '0;
    // Transmit pin forced to output
    pu_ov_en[`PAO_IDX_TXD]   = SERIAL_TX_ENABLE;
    dir_ov_en[`PAO_IDX_TXD]  = SERIAL_TX_ENABLE;
    dir_ov_val[`PAO_IDX_TXD] = 1'b1;
    val_ov_en[`PAO_IDX_TXD]  = SERIAL_TX_ENABLE;
    val_ov_val[`PAO_IDX_TXD] = SERIAL_TX_OUT;
    // Receive pin forced to input, pull-up still from its data bit
    pu_ov_en[`PAO_IDX_RXD]   = SERIAL_RX_ENABLE;
    pu_ov_val[`PAO_IDX_RXD]  = PORT_DATA_D[`PAO_IDX_RXD] & ~GLOBAL_PULLUP_DISABLE;
    dir_ov_en[`PAO_IDX_RXD]  = SERIAL_RX_ENABLE;
    dir_ov_val[`PAO_IDX_RXD] = 1'b0;
    // Two-wire pins: drive low only, direction from the interface
    pu_ov_en[`PAO_IDX_SDA]   = TWO_WIRE_ENABLE;
    pu_ov_val[`PAO_IDX_SDA]  = PORT_DATA_D[`PAO_IDX_SDA] & ~GLOBAL_PULLUP_DISABLE;
    dir_ov_en[`PAO_IDX_SDA]  = TWO_WIRE_ENABLE;
    dir_ov_val[`PAO_IDX_SDA] = TW_SDA_PULL_LOW;
    val_ov_en[`PAO_IDX_SDA]  = TWO_WIRE_ENABLE;
    val_ov_val[`PAO_IDX_SDA] = 1'b0;
    pu_ov_en[`PAO_IDX_SCL]   = TWO_WIRE_ENABLE;
    pu_ov_val[`PAO_IDX_SCL]  = PORT_DATA_D[`PAO_IDX_SCL] & ~GLOBAL_PULLUP_DISABLE;
    dir_ov_en[`PAO_IDX_SCL]  = TWO_WIRE_ENABLE;
    dir_ov_val[`PAO_IDX_SCL] = TW_SCL_PULL_LOW;
    // Compare output shares the clock pin; two-wire keeps the value low
    val_ov_en[`PAO_IDX_SCL]  = TWO_WIRE_ENABLE | TIMER0_COMPARE_B_EN;
    val_ov_val[`PAO_IDX_SCL] = TWO_WIRE_ENABLE ? 1'b0 : TIMER0_COMPARE_B_OUT;
    // Sync clock drives out only in sync mode with direction set
    dir_ov_en[`PAO_IDX_XCK]  = xck_out_en;
    dir_ov_val[`PAO_IDX_XCK] = 1'b1;
    val_ov_en[`PAO_IDX_XCK]  = xck_out_en;
    val_ov_val[`PAO_IDX_XCK] = SERIAL_SYNC_CLOCK_OUT;
    // Interrupt pins keep their input buffer alive
    ie_ov_en[3:0] = EXT_IRQ_EN_D;
    ie_ov_val[3:0] = 4'hF;
    ie_ov_en[`PAO_IDX_IRQ6]  = EXT_IRQ6_EN;
    ie_ov_val[`PAO_IDX_IRQ6] = 1'b1;
    // Test port takes bits 7..4 of port F
    pu_ov_en[23:20]  = {4{JTAG_ENABLE}};
    pu_ov_val[23:20] = JTAG_PU_MASK[7:4];
    dir_ov_en[23:20] = {4{JTAG_ENABLE}};
    dir_ov_val[`PAO_IDX_TDO] = TAP_SHIFT_IR | TAP_SHIFT_DR;
    val_ov_en[`PAO_IDX_TDO]  = JTAG_ENABLE;
    val_ov_val[`PAO_IDX_TDO] = TAP_TDO;
    ie_ov_en[23:20] = {4{JTAG_ENABLE}};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-pin resolution of override against register control
  for (genvar i = 0; i < 24; i++) begin : g_pin
    // Without override, pull-up only for an input with data set; global disable blocks all but the test pull-ups
    assign pu_f[i]  = pu_ov_en[i] ? pu_ov_val[i]
                    : (~dir_reg[i] & data_reg[i] & ~GLOBAL_PULLUP_DISABLE);
    assign dd_f[i]  = dir_ov_en[i] ? dir_ov_val[i] : dir_reg[i];
    assign pv_f[i]  = val_ov_en[i] ? val_ov_val[i] : data_reg[i];
    assign die_f[i] = ie_ov_en[i] ? ie_ov_val[i] : ~INPUT_DISABLE_SLEEP;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state: synchronisers, spike filters, pad drive, boot sampling
  always_comb begin
    st_nxt     = st_r;
    st_nxt.s1  = {PAD_F_IN, PAD_E_IN, PAD_D_IN};
    st_nxt.s2  = st_r.s1;
    st_nxt.pin = st_r.s2 & die_f;
    st_nxt.oe  = dd_f;
    st_nxt.out = pv_f;
    st_nxt.pu  = pu_f;
    // Level must hold the full filter time before it passes
    for (int k = 0; k < 2; k++) begin
      if (st_r.s2[k] == st_r.fval[k]) begin
        st_nxt.fcnt[k] = `PAO_RST_FCNT;
      end else if (st_r.fcnt[k] == FILT_LAST) begin
        st_nxt.fval[k] = st_r.s2[k];
        st_nxt.fcnt[k] = `PAO_RST_FCNT;
      end else begin
        st_nxt.fcnt[k] = st_r.fcnt[k] + 4'h1;
      end
    end
    // Pin level reaches the second stage two edges after release
    case (st_r.boot_st)
      BOOT_WAIT: begin
        st_nxt.boot_st = BOOT_SYNC;
      end
      BOOT_SYNC: begin
        st_nxt.boot_st = BOOT_CAPTURE;
      end
      BOOT_CAPTURE: begin
        st_nxt.boot_st  = BOOT_DONE;
        st_nxt.boot_sel = BOOT_SELECT_FUSE & ~st_r.s2[`PAO_IDX_BOOT];
      end
      BOOT_DONE: begin
        st_nxt.boot_st = BOOT_DONE;
      end
      default: begin
        st_nxt.boot_st = BOOT_WAIT;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r.s1       <= `PAO_RST_PINS;
      st_r.s2       <= `PAO_RST_PINS;
      st_r.fcnt     <= {2{`PAO_RST_FCNT}};
      st_r.fval     <= `PAO_RST_FILT;
      st_r.pin      <= `PAO_RST_PINS;
      st_r.oe       <= `PAO_RST_PINS;
      st_r.out      <= `PAO_RST_PINS;
      st_r.pu       <= `PAO_RST_PINS;
      st_r.boot_st  <= BOOT_WAIT;
      st_r.boot_sel <= `PAO_RST_BOOT;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs; test pull-ups bypass the flops so they hold through reset
  assign PAD_D_OUT    = st_r.out[7:0];
  assign PAD_D_OE     = st_r.oe[7:0];
  assign PAD_D_PULLUP = st_r.pu[7:0];
  assign PAD_E_OUT    = st_r.out[15:8];
  assign PAD_E_OE     = st_r.oe[15:8];
  assign PAD_E_PULLUP = st_r.pu[15:8];
  assign PAD_F_OUT    = st_r.out[23:16];
  assign PAD_F_OE     = st_r.oe[23:16];
  assign PAD_F_PULLUP = st_r.pu[23:16] | ({8{JTAG_ENABLE}} & `PAO_JTAG_PU_MASK);
  assign PIN_D        = st_r.pin[7:0];
  assign PIN_E        = st_r.pin[15:8];
  assign PIN_F        = st_r.pin[23:16];
  assign TW_SDA_IN    = st_r.fval[`PAO_IDX_SDA];
  assign TW_SCL_IN    = st_r.fval[`PAO_IDX_SCL];
  assign SERIAL_RX_IN = st_r.pin[`PAO_IDX_RXD];
  assign SERIAL_SYNC_CLOCK_IN = st_r.pin[`PAO_IDX_XCK];
  assign TIMER0_EXT_CLOCK_IN  = st_r.pin[`PAO_IDX_TMR0CK];
  assign TIMER1_EXT_CLOCK_IN  = st_r.pin[`PAO_IDX_TMR1CK];
  assign TIMER1_CAPTURE_IN    = st_r.pin[`PAO_IDX_CAP1];
  assign EXT_IRQ_IN_D = st_r.pin[3:0];
  assign EXT_IRQ6_IN  = st_r.pin[`PAO_IDX_IRQ6];
  assign BOOT_FROM_LOADER = st_r.boot_sel;
  // Test pins bypass the digital input gate; controller runs on test clock
  assign TAP_TDI = st_r.s2[`PAO_IDX_TDI];
  assign TAP_TMS = st_r.s2[`PAO_IDX_TMS];
  assign TAP_TCK = st_r.s2[`PAO_IDX_TCK];

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  AST_RX_INPUT: assert property (SERIAL_RX_ENABLE |=> !PAD_D_OE[2])
    else $error("receive pin driven while receiver enabled");
  AST_RX_PULL: assert property (SERIAL_RX_ENABLE |=>
      PAD_D_PULLUP[2] == $past(PORT_DATA_D[2] & ~GLOBAL_PULLUP_DISABLE))
    else $error("receive pin pull-up not from data bit");
  AST_TW_SDA: assert property (TWO_WIRE_ENABLE |=>
      !PAD_D_OUT[1] && PAD_D_OE[1] == $past(TW_SDA_PULL_LOW))
    else $error("two-wire data pin not open drain");
  AST_TW_PRIO: assert property (TWO_WIRE_ENABLE && TIMER0_COMPARE_B_EN |=>
      !PAD_D_OUT[0] && PAD_D_OE[0] == $past(TW_SCL_PULL_LOW))
    else $error("compare output overrode two-wire clock");
  AST_CMP_B: assert property (!TWO_WIRE_ENABLE && TIMER0_COMPARE_B_EN |=>
      PAD_D_OUT[0] == $past(TIMER0_COMPARE_B_OUT))
    else $error("compare output missing on port D bit 0");
  AST_FILT: assert property (!$stable(TW_SDA_IN) |->
      $past(st_r.s2[1], 1) == TW_SDA_IN && $past(st_r.fcnt[1]) == FILT_LAST)
    else $error("filtered data changed before filter time");
  AST_TX: assert property (SERIAL_TX_ENABLE |=>
      PAD_D_OE[3] && PAD_D_OUT[3] == $past(SERIAL_TX_OUT))
    else $error("transmit pin not driven with transmit data");
  AST_PUD: assert property (GLOBAL_PULLUP_DISABLE && !JTAG_ENABLE |=> PAD_D_PULLUP == 8'h00)
    else $error("pull-up active under global disable");
  AST_TDO: assert property (JTAG_ENABLE && !TAP_SHIFT_IR && !TAP_SHIFT_DR |=> !PAD_F_OE[6])
    else $error("test data out driven outside shift");
  AST_JTAG_PU: assert property (JTAG_ENABLE |-> PAD_F_PULLUP[7] && PAD_F_PULLUP[5]
      && PAD_F_PULLUP[4])
    else $error("test pin pull-ups off");
  AST_IRQ_DIE: assert property (EXT_IRQ_EN_D[0] ##1 EXT_IRQ_EN_D[0] |=>
      EXT_IRQ_IN_D[0] == $past(st_r.s2[0]))
    else $error("interrupt input gated off while enabled");

  COV_TW_MODE: cover property (TWO_WIRE_ENABLE ##1 PAD_D_OE[1] ##1 !PAD_D_OE[1]);
  COV_FILT_PASS: cover property ($changed(TW_SCL_IN));
  COV_TDO_SHIFT: cover property (JTAG_ENABLE && TAP_SHIFT_DR ##1 PAD_F_OE[6]);
  COV_BOOT: cover property (BOOT_FROM_LOADER);
endmodule : pao_top

// file: verification/pao_pad_model.sv
// Far-side model: external drivers, pull-ups and floating lines on ports D, E, F
`timescale 1ns/1ps
module pao_pad_model (
  // Clock for the floating pattern
  input  wire logic        clk,
  // Pad drive from the block
  input  wire logic [23:0] pad_out,
  input  wire logic [23:0] pad_oe,
  input  wire logic [23:0] pad_pu,
  // External drivers
  input  wire logic [23:0] ext_drv,
  input  wire logic [23:0] ext_val,
  // Resolved wire levels
  output logic      [23:0] pad_lvl
);
  logic [23:0] flt_r = 24'h000000;

  // Floating lines toggle so a stale level is never trusted
  always_ff @(posedge clk) begin
    flt_r <= ~pad_lvl;
  end

  // Block drive wins, then external drive; open drain is OE with OUT low, else pull-up or float
  assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
                 | (~pad_oe & ~ext_drv & (pad_pu | flt_r));
endmodule : pao_pad_model

// file: verification/pao_top_tb_top.sv
// Self-checking testbench for the port override block
`timescale 1ns/1ps
module pao_top_tb_top;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] PORT_DATA_D, PORT_DIR_D, PORT_DATA_E, PORT_DIR_E, PORT_DATA_F, PORT_DIR_F;
  logic GLOBAL_PULLUP_DISABLE, INPUT_DISABLE_SLEEP, SERIAL_RX_ENABLE, SERIAL_TX_ENABLE;
  logic SERIAL_TX_OUT, SERIAL_SYNC_MODE, SERIAL_SYNC_CLOCK_OUT, TWO_WIRE_ENABLE;
  logic TW_SDA_PULL_LOW, TW_SCL_PULL_LOW, TIMER0_COMPARE_B_EN, TIMER0_COMPARE_B_OUT;
  logic EXT_IRQ6_EN, BOOT_SELECT_FUSE, JTAG_ENABLE, TAP_SHIFT_IR, TAP_SHIFT_DR, TAP_TDO;
  logic SERIAL_RX_IN, SERIAL_SYNC_CLOCK_IN, TW_SDA_IN, TW_SCL_IN, TIMER0_EXT_CLOCK_IN;
  logic TIMER1_EXT_CLOCK_IN, TIMER1_CAPTURE_IN, EXT_IRQ6_IN, BOOT_FROM_LOADER;
  logic TAP_TDI, TAP_TMS, TAP_TCK;
  logic [3:0] EXT_IRQ_EN_D, EXT_IRQ_IN_D;
  logic [7:0] PIN_D, PIN_E, PIN_F, PAD_D_IN, PAD_E_IN, PAD_F_IN;
  logic [7:0] PAD_D_OUT, PAD_D_OE, PAD_D_PULLUP, PAD_E_OUT, PAD_E_OE, PAD_E_PULLUP;
  logic [7:0] PAD_F_OUT, PAD_F_OE, PAD_F_PULLUP;
  logic [23:0] ext_drv, ext_val, pad_lvl;
  int n_fail = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////////
  pao_top dut (
    .CLK, .RESETN, .PORT_DATA_D, .PORT_DIR_D, .PORT_DATA_E, .PORT_DIR_E, .PORT_DATA_F,
    .PORT_DIR_F, .GLOBAL_PULLUP_DISABLE, .INPUT_DISABLE_SLEEP, .SERIAL_RX_ENABLE,
    .SERIAL_TX_ENABLE, .SERIAL_TX_OUT, .SERIAL_SYNC_MODE, .SERIAL_SYNC_CLOCK_OUT,
    .SERIAL_RX_IN, .SERIAL_SYNC_CLOCK_IN, .TWO_WIRE_ENABLE, .TW_SDA_PULL_LOW,
    .TW_SCL_PULL_LOW, .TW_SDA_IN, .TW_SCL_IN, .TIMER0_COMPARE_B_EN, .TIMER0_COMPARE_B_OUT,
    .TIMER0_EXT_CLOCK_IN, .TIMER1_EXT_CLOCK_IN, .TIMER1_CAPTURE_IN, .EXT_IRQ_EN_D,
    .EXT_IRQ6_EN, .EXT_IRQ_IN_D, .EXT_IRQ6_IN, .BOOT_SELECT_FUSE, .BOOT_FROM_LOADER,
    .JTAG_ENABLE, .TAP_SHIFT_IR, .TAP_SHIFT_DR, .TAP_TDO, .TAP_TDI, .TAP_TMS, .TAP_TCK,
    .PIN_D, .PIN_E, .PIN_F, .PAD_D_IN, .PAD_E_IN, .PAD_F_IN, .PAD_D_OUT, .PAD_D_OE,
    .PAD_D_PULLUP, .PAD_E_OUT, .PAD_E_OE, .PAD_E_PULLUP, .PAD_F_OUT, .PAD_F_OE,
    .PAD_F_PULLUP
  );
  pao_pad_model pads (
    .clk(CLK), .pad_out({PAD_F_OUT, PAD_E_OUT, PAD_D_OUT}),
    .pad_oe({PAD_F_OE, PAD_E_OE, PAD_D_OE}),
    .pad_pu({PAD_F_PULLUP, PAD_E_PULLUP, PAD_D_PULLUP}), .ext_drv, .ext_val, .pad_lvl
  );
  assign {PAD_F_IN, PAD_E_IN, PAD_D_IN} = pad_lvl;

  // 200 MHz clock
  always #2.5 CLK = ~CLK;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Inputs move 1 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step

  // Clear all stimulus, then let an edge pass so no signal is set twice at once
  task automatic idle();
    {PORT_DATA_D, PORT_DIR_D, PORT_DATA_E, PORT_DIR_E, PORT_DATA_F, PORT_DIR_F} = '0;
    {GLOBAL_PULLUP_DISABLE, INPUT_DISABLE_SLEEP, SERIAL_RX_ENABLE, SERIAL_TX_ENABLE} = '0;
    {SERIAL_TX_OUT, SERIAL_SYNC_MODE, SERIAL_SYNC_CLOCK_OUT, TWO_WIRE_ENABLE} = '0;
    {TW_SDA_PULL_LOW, TW_SCL_PULL_LOW, TIMER0_COMPARE_B_EN, TIMER0_COMPARE_B_OUT} = '0;
    {EXT_IRQ_EN_D, EXT_IRQ6_EN, BOOT_SELECT_FUSE, JTAG_ENABLE} = '0;
    {TAP_SHIFT_IR, TAP_SHIFT_DR, TAP_TDO, ext_drv, ext_val} = '0;
    step(1);
  endtask : idle

  // Reset with a boot pin level; the pin is released to plain I/O after
  task automatic do_reset(input logic fuse, input logic e2, input logic jtag);
    idle();
    RESETN = 1'b0;
    {BOOT_SELECT_FUSE, JTAG_ENABLE, ext_drv[10], ext_val[10]} = {fuse, jtag, 1'b1, e2};
    step(1);
    check({TW_SDA_IN, TW_SCL_IN}, 8'h03);
    check(PAD_F_PULLUP, {jtag, 1'b0, jtag, jtag, 4'h0});
    RESETN = 1'b1;
    step(3);
    check(BOOT_FROM_LOADER, fuse & ~e2);
    {ext_val[10], PORT_DIR_E, PORT_DATA_E} = {~e2, 8'h04, 8'h44};
    step(4);
    check(BOOT_FROM_LOADER, fuse & ~e2);
    check(PAD_E_OE & PAD_E_OUT, 8'h04);
    check(PAD_E_PULLUP, 8'h40);
  endtask : do_reset

  task automatic t_serial();
    idle();
    {PORT_DATA_D, PORT_DIR_D, SERIAL_TX_ENABLE, SERIAL_TX_OUT} = {8'hAC, 8'h04, 2'b11};
    SERIAL_RX_ENABLE = 1'b1;
    step(1);
    check(PAD_D_OE, 8'h08);
    check(PAD_D_OUT[3], 1'b1);
    check(PAD_D_PULLUP, 8'hA4);
    {GLOBAL_PULLUP_DISABLE, SERIAL_TX_OUT, SERIAL_RX_ENABLE} = 3'b100;
    step(1);
    check(PAD_D_PULLUP, 8'h00);
    check(PAD_D_OUT[3], 1'b0);
    check(PAD_D_OE, 8'h0C);
  endtask : t_serial

  task automatic t_sync();
    idle();
    {SERIAL_SYNC_MODE, PORT_DIR_D, SERIAL_SYNC_CLOCK_OUT} = {1'b1, 8'h20, 1'b1};
    step(1);
    check(PAD_D_OE & PAD_D_OUT, 8'h20);
    SERIAL_SYNC_MODE = 1'b0;
    step(1);
    check(PAD_D_OUT, 8'h00);
    {PORT_DIR_D, SERIAL_SYNC_MODE, ext_drv[5], ext_val[5]} = {8'h00, 3'b111};
    // Pad is freed one edge after the drive drops, then three edges to the pin
    step(4);
    check(SERIAL_SYNC_CLOCK_IN, 1'b1);
    check(PAD_D_OE, 8'h00);
  endtask : t_sync

  task automatic t_two_wire();
    idle();
    {TWO_WIRE_ENABLE, TIMER0_COMPARE_B_EN, TIMER0_COMPARE_B_OUT, TW_SDA_PULL_LOW} = 4'hF;
    {PORT_DIR_D, PORT_DATA_D} = {8'h03, 8'h03};
    step(1);
    check(PAD_D_OE & 8'h03, 8'h02);
    check(PAD_D_OUT & 8'h03, 8'h00);
    check(PAD_D_PULLUP & 8'h03, 8'h03);
    {TW_SCL_PULL_LOW, TW_SDA_PULL_LOW} = 2'b10;
    step(1);
    check(PAD_D_OE & 8'h03, 8'h01);
    TWO_WIRE_ENABLE = 1'b0;
    step(1);
    check(PAD_D_OE & PAD_D_OUT & 8'h03, 8'h03);
    TIMER0_COMPARE_B_OUT = 1'b0;
    step(1);
    check(PAD_D_OUT & 8'h03, 8'h02);
  endtask : t_two_wire

  // A 9-cycle dip must vanish; a lasting change shows 12 edges later
  task automatic t_filter();
    idle();
    {TWO_WIRE_ENABLE, ext_drv[1:0], ext_val[1:0]} = 5'h1F;
    step(14);
    ext_val[1:0] = 2'b00;
    step(9);
    ext_val[1:0] = 2'b11;
    for (int i = 0; i < 14; i++) begin
      step(1);
      check({TW_SDA_IN, TW_SCL_IN}, 8'h03);
    end
    ext_val[1:0] = 2'b00;
    step(11);
    check({TW_SDA_IN, TW_SCL_IN}, 8'h03);
    step(1);
    check({TW_SDA_IN, TW_SCL_IN}, 8'h00);
  endtask : t_filter

  task automatic t_irq();
    idle();
    {INPUT_DISABLE_SLEEP, EXT_IRQ_EN_D, EXT_IRQ6_EN} = 6'h3F;
    {ext_drv, ext_val} = {24'h0040FF, 24'h00405A};
    step(3);
    check(EXT_IRQ_IN_D, 8'h0A);
    check(PIN_D, 8'h0A);
    check(EXT_IRQ6_IN, 8'h01);
    check(PIN_E, 8'h40);
    {EXT_IRQ_EN_D, EXT_IRQ6_EN, ext_val[7:0]} = {4'h5, 1'b0, 8'h55};
    step(3);
    check(PIN_D, 8'h05);
    check(PIN_E, 8'h00);
    // Input buffers back on: timer, capture and receive inputs follow their pins
    INPUT_DISABLE_SLEEP = 1'b0;
    step(3);
    check(PIN_D, 8'h55);
    check({TIMER0_EXT_CLOCK_IN, TIMER1_EXT_CLOCK_IN}, 8'h01);
    check({TIMER1_CAPTURE_IN, SERIAL_RX_IN}, 8'h03);
  endtask : t_irq

  task automatic t_jtag();
    idle();
    {JTAG_ENABLE, PORT_DIR_F, PORT_DATA_F} = {1'b1, 16'hFFFF};
    {ext_drv, ext_val} = {24'hB00000, 24'h900000};
    for (int k = 0; k < 3; k++) begin
      {TAP_SHIFT_DR, TAP_SHIFT_IR, TAP_TDO} = {k[1:0], k[0]};
      step(3);
      check(PAD_F_OE, {1'b0, k != 0, 6'h0F});
      check(PAD_F_PULLUP, 8'hB0);
      check(PAD_F_OUT[6], k[0]);
      check({TAP_TDI, TAP_TMS, TAP_TCK}, 8'h05);
      check(PIN_F & 8'hF0, 8'h00);
    end
    JTAG_ENABLE = 1'b0;
    step(1);
    check(PAD_F_OE, 8'hFF);
  endtask : t_jtag

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Whole run is about 113 cycles; this cuts a hang short
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end

  initial begin
    do_reset(1'b1, 1'b0, 1'b1);
    do_reset(1'b1, 1'b1, 1'b0);
    do_reset(1'b0, 1'b0, 1'b0);
    t_serial();
    t_sync();
    t_two_wire();
    t_filter();
    t_irq();
    t_jtag();
    end_of_test();
  end
endmodule : pao_top_tb_top
